/* verilog/eip_consts.svh */
`ifndef EIP_CONSTS_SVH
`define EIP_CONSTS_SVH

// special-function addresses, reachable from every page
`define EIP_ADDR_PRIO_HIGH 8'h86
`define EIP_ADDR_ENABLE 8'haf
`define EIP_ADDR_PRIO_LOW 8'hbf
`define EIP_ADDR_PIN_CFG 8'he4

// bit positions shared by enable and both priority registers
`define EIP_BIT_TEMP 3
`define EIP_BIT_TIMER5 2
`define EIP_BIT_TIMER4 1
`define EIP_BIT_SERIAL2 0
`define EIP_SRC_BITS 4

// pin configuration fields
`define EIP_PINCFG_A_SEL_LO 0
`define EIP_PINCFG_A_POL 3
`define EIP_PINCFG_B_SEL_LO 4
`define EIP_PINCFG_B_POL 7
`define EIP_SEL_W 3

// reset values
`define EIP_SRC_RESET 4'h0
`define EIP_PINCFG_RESET 8'h01
`define EIP_BYTE_ZERO 8'h00

`endif

/* verilog/eip_pkg.sv */
`default_nettype none
package eip_pkg;
    typedef enum logic [2:0] {
        EIP_SRC_PIN_A,
        EIP_SRC_PIN_B,
        EIP_SRC_SERIAL2,
        EIP_SRC_TIMER4,
        EIP_SRC_TIMER5,
        EIP_SRC_TEMP
    } eip_src_t;

    typedef struct packed {
        logic prevActive;
        logic pending;
    } eip_sense_t;

    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] prioLow;
        logic [3:0] prioHigh;
        logic [7:0] pinCfg;
        logic [7:0] rdata;
    } eip_regs_t;
endpackage
`default_nettype wire

/* verilog/eip_pin_sense.sv */
`timescale 1ns/100ps
`default_nettype none
module eip_pin_sense
    import eip_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pinLevel,
    input wire logic edgeSelect,
    input wire logic polarity,
    input wire logic ackClear,
    output logic pending
);
    eip_sense_t state_ff;
    eip_sense_t nxt_state;
    logic active;
    logic rise;

    assign active = ~(pinLevel ^ polarity);
    assign rise = active & ~state_ff.prevActive;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.prevActive = active;
        if (edgeSelect) begin
            // set wins over the vector clear
            nxt_state.pending = rise | (state_ff.pending & ~ackClear);
        end else begin
            nxt_state.pending = active;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pending = state_ff.pending;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence riseSeen;
        edgeSelect && active && !state_ff.prevActive;
    endsequence

    sequence ackOnly;
        edgeSelect && ackClear && !rise;
    endsequence

    chk_edge_set: assert property (riseSeen |=> pending)
        else $error("edge on pin did not set pending");
    chk_edge_clear: assert property (ackOnly |=> !pending)
        else $error("vector did not clear edge pending");
    chk_level_follow: assert property (
        !edgeSelect |=> pending == ($past(pinLevel) ~^ $past(polarity)))
        else $error("level pending does not follow input");
    chk_edge_hold: assert property (
        edgeSelect && pending && !ackClear ##1 edgeSelect |-> pending)
        else $error("edge pending dropped without vector");
endmodule
`default_nettype wire

/* verilog/eip_ext_irq_enable_priority.sv */
`timescale 1ns/100ps
`default_nettype none
`include "eip_consts.svh"
// Summary of operation
// - bit 3 gates temperature sensor requests
// - bit 2 gates timer 5 overflow requests
// - bit 1 gates timer 4 overflow requests
// - bit 0 gates second serial port requests
// - enable register at 0xaf, resets zero
// - low priority bits at 0xbf
// - high priority bits at 0x86
// - type bit edge/level, polarity bit high/low
// - one pending flag per external pin
// - edge pending cleared on vectoring
// - level pending follows active input
// - three-bit field picks port 0 pin
module eip_ext_irq_enable_priority
    import eip_pkg::*;
#(
    parameter int NUM_SRC = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWe,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic [7:0] port0Pins,
    input wire logic pinAEdgeSelect,
    input wire logic pinBEdgeSelect,
    input wire logic pinAIrqEnable,
    input wire logic pinBIrqEnable,
    input wire logic [1:0] pinAPrio,
    input wire logic [1:0] pinBPrio,
    input wire logic tempSensorReq,
    input wire logic timer5LowOverflow,
    input wire logic timer5HighOverflow,
    input wire logic timer4LowOverflow,
    input wire logic timer4HighOverflow,
    input wire logic serial2Req,
    input wire logic irqAck,
    output logic pinAPending,
    output logic pinBPending,
    output logic irqValid,
    output eip_src_t irqId,
    output logic [1:0] irqPrio
);
    eip_regs_t state_ff;
    eip_regs_t nxt_state;
    logic [NUM_SRC-1:0] reqVec;
    logic [2*NUM_SRC-1:0] prioVec;
    logic [2:0] bestIdx;
    logic pinALevel;
    logic pinBLevel;
    logic ackPinA;
    logic ackPinB;
    logic higherExists;

    function automatic logic [1:0] prio_of(input logic [3:0] hi,
                                           input logic [3:0] lo,
                                           input int bitPos);
        prio_of = {hi[bitPos], lo[bitPos]};
    endfunction

    function automatic logic [2:0] pick_best(
        input logic [NUM_SRC-1:0] req,
        input logic [2*NUM_SRC-1:0] prios);
        logic found;
        logic [1:0] bestP;
        found = 1'b0;
        bestP = 2'h0;
        pick_best = 3'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            // strict compare keeps the lower index on a tie
            if (req[i] && (!found || prios[2*i+:2] > bestP)) begin
                found = 1'b1;
                bestP = prios[2*i+:2];
                pick_best = 3'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin selection, monitored without touching the port
    assign pinALevel = port0Pins[state_ff.pinCfg[`EIP_PINCFG_A_SEL_LO
        +: `EIP_SEL_W]];
    assign pinBLevel = port0Pins[state_ff.pinCfg[`EIP_PINCFG_B_SEL_LO
        +: `EIP_SEL_W]];

    assign ackPinA = irqAck && irqValid && irqId == EIP_SRC_PIN_A;
    assign ackPinB = irqAck && irqValid && irqId == EIP_SRC_PIN_B;

    eip_pin_sense senseA (
        .clk(clk),
        .rst_b(rst_b),
        .pinLevel(pinALevel),
        .edgeSelect(pinAEdgeSelect),
        .polarity(state_ff.pinCfg[`EIP_PINCFG_A_POL]),
        .ackClear(ackPinA),
        .pending(pinAPending)
    );

    eip_pin_sense senseB (
        .clk(clk),
        .rst_b(rst_b),
        .pinLevel(pinBLevel),
        .edgeSelect(pinBEdgeSelect),
        .polarity(state_ff.pinCfg[`EIP_PINCFG_B_POL]),
        .ackClear(ackPinB),
        .pending(pinBPending)
    );

    ////////////////////////////////////////////////////////////////////////
    // masking and arbitration
    always_comb begin
        reqVec = '0;
        reqVec[EIP_SRC_PIN_A] = pinAPending & pinAIrqEnable;
        reqVec[EIP_SRC_PIN_B] = pinBPending & pinBIrqEnable;
        reqVec[EIP_SRC_SERIAL2] = serial2Req
            & state_ff.enable[`EIP_BIT_SERIAL2];
        reqVec[EIP_SRC_TIMER4] = (timer4LowOverflow | timer4HighOverflow)
            & state_ff.enable[`EIP_BIT_TIMER4];
        reqVec[EIP_SRC_TIMER5] = (timer5LowOverflow | timer5HighOverflow)
            & state_ff.enable[`EIP_BIT_TIMER5];
        reqVec[EIP_SRC_TEMP] = tempSensorReq
            & state_ff.enable[`EIP_BIT_TEMP];
        prioVec = '0;
        prioVec[2*EIP_SRC_PIN_A+:2] = pinAPrio;
        prioVec[2*EIP_SRC_PIN_B+:2] = pinBPrio;
        prioVec[2*EIP_SRC_SERIAL2+:2] = prio_of(state_ff.prioHigh,
            state_ff.prioLow, `EIP_BIT_SERIAL2);
        prioVec[2*EIP_SRC_TIMER4+:2] = prio_of(state_ff.prioHigh,
            state_ff.prioLow, `EIP_BIT_TIMER4);
        prioVec[2*EIP_SRC_TIMER5+:2] = prio_of(state_ff.prioHigh,
            state_ff.prioLow, `EIP_BIT_TIMER5);
        prioVec[2*EIP_SRC_TEMP+:2] = prio_of(state_ff.prioHigh,
            state_ff.prioLow, `EIP_BIT_TEMP);
    end

    assign bestIdx = pick_best(reqVec, prioVec);
    assign irqValid = |reqVec;
    assign irqId = eip_src_t'(bestIdx);
    assign irqPrio = prioVec[2*bestIdx+:2];

    ////////////////////////////////////////////////////////////////////////
    // register file
    always_comb begin
        nxt_state = state_ff;
        if (sfrWe) begin
            if (sfrAddr == `EIP_ADDR_ENABLE) begin
                nxt_state.enable = sfrWdata[`EIP_SRC_BITS-1:0];
            end else if (sfrAddr == `EIP_ADDR_PRIO_LOW) begin
                nxt_state.prioLow = sfrWdata[`EIP_SRC_BITS-1:0];
            end else if (sfrAddr == `EIP_ADDR_PRIO_HIGH) begin
                nxt_state.prioHigh = sfrWdata[`EIP_SRC_BITS-1:0];
            end else if (sfrAddr == `EIP_ADDR_PIN_CFG) begin
                nxt_state.pinCfg = sfrWdata;
            end
        end
        // reserved upper nibbles read as zero
        if (sfrAddr == `EIP_ADDR_ENABLE) begin
            nxt_state.rdata = {4'h0, state_ff.enable};
        end else if (sfrAddr == `EIP_ADDR_PRIO_LOW) begin
            nxt_state.rdata = {4'h0, state_ff.prioLow};
        end else if (sfrAddr == `EIP_ADDR_PRIO_HIGH) begin
            nxt_state.rdata = {4'h0, state_ff.prioHigh};
        end else if (sfrAddr == `EIP_ADDR_PIN_CFG) begin
            nxt_state.rdata = state_ff.pinCfg;
        end else begin
            nxt_state.rdata = `EIP_BYTE_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff.enable <= `EIP_SRC_RESET;
            state_ff.prioLow <= `EIP_SRC_RESET;
            state_ff.prioHigh <= `EIP_SRC_RESET;
            state_ff.pinCfg <= `EIP_PINCFG_RESET;
            state_ff.rdata <= `EIP_BYTE_ZERO;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sfrRdata = state_ff.rdata;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    always_comb begin
        higherExists = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (reqVec[i] && prioVec[2*i+:2] > irqPrio) begin
                higherExists = 1'b1;
            end
        end
    end

    sequence enableWrite;
        sfrWe && sfrAddr == `EIP_ADDR_ENABLE;
    endsequence

    chk_temp_gate: assert property (
        irqValid && irqId == EIP_SRC_TEMP |-> state_ff.enable[3])
        else $error("masked temperature request served");
    chk_timer5_gate: assert property (
        irqValid && irqId == EIP_SRC_TIMER5 |-> state_ff.enable[2]
        && (timer5LowOverflow || timer5HighOverflow))
        else $error("timer 5 served without enable or flag");
    chk_timer4_gate: assert property (
        irqValid && irqId == EIP_SRC_TIMER4 |-> state_ff.enable[1]
        && (timer4LowOverflow || timer4HighOverflow))
        else $error("timer 4 served without enable or flag");
    chk_serial_gate: assert property (
        serial2Req && state_ff.enable[0] |-> irqValid)
        else $error("enabled serial request not raised");
    chk_enable_readback: assert property (
        enableWrite ##1 sfrAddr == `EIP_ADDR_ENABLE && !sfrWe
        |=> sfrRdata == {4'h0, $past(sfrWdata[3:0], 2)})
        else $error("enable register readback wrong");
    chk_prio_field: assert property (
        irqValid && irqId == EIP_SRC_TEMP
        |-> irqPrio == {state_ff.prioHigh[3], state_ff.prioLow[3]})
        else $error("temperature priority field wrong");
    chk_best_wins: assert property (irqValid |-> !higherExists)
        else $error("lower priority source served first");
    chk_pin_select: assert property (
        !pinAEdgeSelect && state_ff.pinCfg[`EIP_PINCFG_A_POL]
        && $stable(state_ff.pinCfg) |=> pinAPending == $past(pinALevel))
        else $error("selected pin not monitored");
endmodule
`default_nettype wire

/* bench/eip_irq_requester.sv */
`timescale 1ns/100ps
`default_nettype none
// external level requester on one port 0 pin
module eip_irq_requester (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic raise,
    input wire logic activeHigh,
    input wire logic recognised,
    output logic pinLevel
);
    logic active_ff;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_ff <= 1'b0;
        end else if (recognised) begin
            active_ff <= 1'b0;
        end else if (raise) begin
            active_ff <= 1'b1;
        end
    end
    assign pinLevel = active_ff ~^ activeHigh;
endmodule
`default_nettype wire

/* bench/eip_testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define EIP_CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
nErrors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module testbench
    import eip_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, port0Pins;
    logic [7:0] otherPins = 8'hff;
    logic sfrWe = 1'b0, irqAck = 1'b0, raise = 1'b0, reqPin;
    logic pinAEdge = 1'b0, pinBEdge = 1'b0, pinAEn = 1'b0, pinBEn = 1'b0;
    logic [1:0] pinAPrio = 2'h3, pinBPrio = 2'h1, irqPrio;
    logic [5:0] srcReq = 6'h00;
    logic pinAPending, pinBPending, irqValid;
    eip_src_t irqId;
    int nErrors = 0, checked = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    // requester owns port 0 bit 5, no peripheral routed there
    assign port0Pins = {otherPins[7:6], reqPin, otherPins[4:0]};
    eip_irq_requester requester (.clk(clk), .rst_b(rst_b), .raise(raise),
        .activeHigh(1'b1), .recognised(irqAck && irqId == EIP_SRC_PIN_A),
        .pinLevel(reqPin));
    eip_ext_irq_enable_priority #(.NUM_SRC(6)) dut (
        .clk(clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWe(sfrWe),
        .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .port0Pins(port0Pins),
        .pinAEdgeSelect(pinAEdge), .pinBEdgeSelect(pinBEdge),
        .pinAIrqEnable(pinAEn), .pinBIrqEnable(pinBEn), .pinAPrio(pinAPrio),
        .pinBPrio(pinBPrio), .tempSensorReq(srcReq[5]),
        .timer5HighOverflow(srcReq[4]), .timer5LowOverflow(srcReq[3]),
        .timer4HighOverflow(srcReq[2]), .timer4LowOverflow(srcReq[1]),
        .serial2Req(srcReq[0]), .irqAck(irqAck), .pinAPending(pinAPending),
        .pinBPending(pinBPending), .irqValid(irqValid), .irqId(irqId),
        .irqPrio(irqPrio));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr <= a;
        sfrWe <= 1'b1;
        sfrWdata <= d;
        @(posedge clk);
        sfrWe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk);
        sfrAddr <= a;
        @(posedge clk);
        #1 `EIP_CHK("sfrRdata", ex, sfrRdata)
    endtask
    task automatic t_regs;
        rd(8'haf, 8'h00);
        rd(8'hbf, 8'h00);
        rd(8'h86, 8'h00);
        rd(8'he4, 8'h01);
        wr(8'haf, 8'hff);
        wr(8'hbf, 8'hf5);
        wr(8'h86, 8'h3a);
        wr(8'h10, 8'hff);
        rd(8'haf, 8'h0f);
        rd(8'hbf, 8'h05);
        rd(8'h86, 8'h0a);
        rd(8'h10, 8'h00);
    endtask
    // each source alone: masked by every other bit, passed by its own
    task automatic t_mask;
        int b;
        for (int i = 0; i < 6; i++) begin
            b = (i + 1) / 2;
            @(posedge clk);
            srcReq <= 6'h01 << i;
            wr(8'haf, 8'h0f ^ (8'h01 << b));
            #1 `EIP_CHK("irqValid", 1'b0, irqValid)
            wr(8'haf, 8'h01 << b);
            #1 `EIP_CHK("irqValid", 1'b1, irqValid)
            `EIP_CHK("irqId", 3'(b + 2), irqId)
        end
    endtask
    task automatic t_prio;
        logic [7:0] lo [5] = '{8'h02, 8'h02, 8'h02, 8'h0c, 8'h00};
        logic [7:0] hi [5] = '{8'h08, 8'h02, 8'h00, 8'h0c, 8'h00};
        logic [2:0] id [5] = '{3'h5, 3'h3, 3'h3, 3'h4, 3'h2};
        logic [1:0] pr [5] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h0};
        @(posedge clk);
        srcReq <= 6'h2b;
        wr(8'haf, 8'h0f);
        for (int i = 0; i < 5; i++) begin
            wr(8'hbf, lo[i]);
            wr(8'h86, hi[i]);
            #1 `EIP_CHK("irqId", id[i], irqId)
            `EIP_CHK("irqPrio", pr[i], irqPrio)
        end
        @(posedge clk);
        srcReq <= 6'h00;
    endtask
    // pin A level, active high, on bit 5; pin B stays active low on bit 0
    task automatic t_level;
        wr(8'he4, 8'h0d);
        rd(8'he4, 8'h0d);
        @(posedge clk);
        pinAEn <= 1'b1;
        raise <= 1'b1;
        @(posedge clk);
        raise <= 1'b0;
        @(posedge clk);
        #1 `EIP_CHK("pinAPending", 1'b1, pinAPending)
        `EIP_CHK("irqId", EIP_SRC_PIN_A, irqId)
        @(posedge clk);
        irqAck <= 1'b1;
        @(posedge clk);
        irqAck <= 1'b0;
        @(posedge clk);
        #1 `EIP_CHK("pinAPending", 1'b0, pinAPending)
    endtask
    // pin B edge: short low pulse must stay latched until acknowledged
    task automatic t_edge;
        @(posedge clk);
        pinAEn <= 1'b0;
        pinBEn <= 1'b1;
        pinBEdge <= 1'b1;
        otherPins[0] <= 1'b0;
        @(posedge clk);
        otherPins[0] <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `EIP_CHK("pinBPending", 1'b1, pinBPending)
        `EIP_CHK("irqId", EIP_SRC_PIN_B, irqId)
        @(posedge clk);
        irqAck <= 1'b1;
        @(posedge clk);
        irqAck <= 1'b0;
        #1 `EIP_CHK("pinBPending", 1'b0, pinBPending)
    endtask
    // pin A edge, active high on bit 5, cleared by its own vector
    task automatic t_edge_a;
        @(posedge clk);
        pinBEn <= 1'b0;
        pinAEn <= 1'b1;
        pinAEdge <= 1'b1;
        raise <= 1'b1;
        @(posedge clk);
        raise <= 1'b0;
        @(posedge clk);
        #1 `EIP_CHK("pinAPending", 1'b1, pinAPending)
        `EIP_CHK("irqId", EIP_SRC_PIN_A, irqId)
        @(posedge clk);
        irqAck <= 1'b1;
        @(posedge clk);
        irqAck <= 1'b0;
        #1 `EIP_CHK("pinAPending", 1'b0, pinAPending)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (nErrors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            nErrors++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_mask();
        t_prio();
        t_level();
        t_edge();
        t_edge_a();
        finish_test();
    end
endmodule
`default_nettype wire
